/* rtl/scrs_pkg.sv */
// constants for the startup clock and reset sequencer
// assumes the reference clock input is the block clock sys_clk at 50 MHz
package scrs_pkg;

  // reference clock cycles the core is held after the processor reset pin releases
  localparam int LOCK_CYCLES = 4096;
  localparam logic [11:0] LOCK_LAST = 12'(LOCK_CYCLES - 1);
  localparam logic [12:0] LOCK_LEN = 13'(LOCK_CYCLES);

  // startup ratio strap codes
  localparam logic [1:0] STRAP_8 = 2'h0;
  localparam logic [1:0] STRAP_32 = 2'h1;
  localparam logic [1:0] STRAP_16 = 2'h2;
  localparam logic [1:0] STRAP_RSVD = 2'h3;

  // core to reference clock multipliers
  localparam logic [5:0] MULT_8 = 6'h08;
  localparam logic [5:0] MULT_16 = 6'h10;
  localparam logic [5:0] MULT_32 = 6'h20;
  localparam logic [1:0] DIV_STARTUP = 2'h1;

  // values after reset
  localparam logic [5:0] MULT_RESET = 6'h08;
  localparam logic [1:0] DIV_RESET = 2'h1;
  localparam logic [11:0] LOCK_CNT_RESET = 12'h000;
  localparam logic [1:0] STRAP_SYNC_RESET = 2'h0;
  localparam logic PIN_RESET_N_SYNC_RESET = 1'h0;

  // hardware reset vector of the core
  localparam logic [23:0] RESET_VECTOR = 24'h000000;

  typedef enum logic [1:0] {ST_RESET, ST_LOCK, ST_RUN} scrs_state_e;

endpackage

/* rtl/scrs_pin_sync.sv */
// three flip-flop pin synchroniser with agreement filter
// assumes inputs are asynchronous to sys_clk; reset is synchronous
`timescale 1ns/1ps
module scrs_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // only the second and third stage are compared; the first feeds the second alone
  always_comb
  begin
    level_next = level_reg;
    if (ff2_reg == ff3_reg)
    begin
      level_next = ff3_reg;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ff1_reg <= RESET_VAL;
      ff2_reg <= RESET_VAL;
      ff3_reg <= RESET_VAL;
      level_reg <= RESET_VAL;
    end
    else
    begin
      ff1_reg <= pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule

/* rtl/scrs_startup_sequencer.sv */
// startup clock and reset sequencer: strap decode, pll lock wait, core release
// assumes sys_clk is the reference clock input and runs free without change
`timescale 1ns/1ps
module scrs_startup_sequencer
  import scrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic proc_reset_n,
  input wire logic [1:0] clk_ratio_strap,
  input wire logic pll_wr,
  input wire logic [5:0] pll_mult_in,
  input wire logic [1:0] pll_div_in,
  output logic core_reset,
  output logic core_start,
  output logic [23:0] fetch_addr,
  output logic [5:0] pll_mult,
  output logic [1:0] pll_div,
  output logic strap_reserved,
  output logic pll_locked
);

  logic pin_reset_n_f;
  logic [1:0] strap_f;
  scrs_state_e state_reg;
  scrs_state_e state_next;
  logic [11:0] lock_cnt_reg;
  logic [11:0] lock_cnt_next;
  logic [5:0] mult_reg;
  logic [5:0] mult_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic rsvd_reg;
  logic rsvd_next;
  logic core_reset_reg;
  logic core_reset_next;
  logic core_start_reg;
  logic core_start_next;
  logic [23:0] fetch_reg;
  logic [23:0] fetch_next;

  // the board holds the pin low at power-up, so a low reset value is safe
  scrs_pin_sync #(
    .WIDTH(1),
    .RESET_VAL(PIN_RESET_N_SYNC_RESET)
  ) u_reset_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(proc_reset_n),
    .level(pin_reset_n_f)
  );

  scrs_pin_sync #(
    .WIDTH(2),
    .RESET_VAL(STRAP_SYNC_RESET)
  ) u_strap_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(clk_ratio_strap),
    .level(strap_f)
  );

  // sequencing state
  always_comb
  begin
    state_next = state_reg;
    lock_cnt_next = lock_cnt_reg;
    core_reset_next = core_reset_reg;
    core_start_next = 1'b0;
    fetch_next = fetch_reg;
    case (state_reg)
      ST_RESET:
      begin
        core_reset_next = 1'b1;
        lock_cnt_next = LOCK_CNT_RESET;
        if (pin_reset_n_f)
        begin
          state_next = ST_LOCK;
        end
      end
      ST_LOCK:
      begin
        core_reset_next = 1'b1;
        lock_cnt_next = lock_cnt_reg + 12'h001;
        if (lock_cnt_reg == LOCK_LAST)
        begin
          state_next = ST_RUN;
          core_reset_next = 1'b0;
          core_start_next = 1'b1;
          fetch_next = RESET_VECTOR;
          lock_cnt_next = LOCK_CNT_RESET;
        end
      end
      ST_RUN:
      begin
        core_reset_next = 1'b0;
      end
      default:
      begin
        state_next = ST_RESET;
        core_reset_next = 1'b1;
      end
    endcase
    // a pin reset restarts the whole sequence from any state
    if (!pin_reset_n_f)
    begin
      state_next = ST_RESET;
      core_reset_next = 1'b1;
      core_start_next = 1'b0;
      lock_cnt_next = LOCK_CNT_RESET;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= ST_RESET;
      lock_cnt_reg <= LOCK_CNT_RESET;
      core_reset_reg <= 1'b1;
      core_start_reg <= 1'b0;
      fetch_reg <= RESET_VECTOR;
    end
    else
    begin
      state_reg <= state_next;
      lock_cnt_reg <= lock_cnt_next;
      core_reset_reg <= core_reset_next;
      core_start_reg <= core_start_next;
      fetch_reg <= fetch_next;
    end
  end

  // clock ratio state
  always_comb
  begin
    mult_next = mult_reg;
    div_next = div_reg;
    rsvd_next = rsvd_reg;
    if (state_reg == ST_RESET)
    begin
      div_next = DIV_STARTUP;
      rsvd_next = 1'b0;
      case (strap_f)
        STRAP_8: mult_next = MULT_8;
        STRAP_32: mult_next = MULT_32;
        STRAP_16: mult_next = MULT_16;
        STRAP_RSVD:
        begin
          // reserved code falls back to the slowest ratio and is flagged
          mult_next = MULT_8;
          rsvd_next = 1'b1;
        end
        default: mult_next = MULT_8;
      endcase
    end
    else if (state_reg == ST_RUN && pll_wr)
    begin
      mult_next = pll_mult_in;
      div_next = pll_div_in;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mult_reg <= MULT_RESET;
      div_reg <= DIV_RESET;
      rsvd_reg <= 1'b0;
    end
    else
    begin
      mult_reg <= mult_next;
      div_reg <= div_next;
      rsvd_reg <= rsvd_next;
    end
  end

  assign core_reset = core_reset_reg;
  assign core_start = core_start_reg;
  assign fetch_addr = fetch_reg;
  assign pll_mult = mult_reg;
  assign pll_div = div_reg;
  assign strap_reserved = rsvd_reg;
  // writes during the lock wait are ignored, so software sees lock only once it may write
  assign pll_locked = (state_reg == ST_RUN);

  // helper: length of the current lock wait, counted independently of lock_cnt_reg
  logic [12:0] wait_len_reg;
  always_ff @(posedge sys_clk)
  begin
    if (srst || state_reg != ST_LOCK)
    begin
      wait_len_reg <= 13'h0000;
    end
    else
    begin
      wait_len_reg <= wait_len_reg + 13'h0001;
    end
  end

  strap_decode_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_RESET && pin_reset_n_f && strap_f == STRAP_32) |=> (mult_reg == 6'h20 && div_reg == 2'h1))
    else $error("strap 01 did not give 32:1");

  strap_sixteen_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_RESET && strap_f == STRAP_16) |=> (mult_reg == 6'h10 && !strap_reserved))
    else $error("strap 10 did not give 16:1");

  pll_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_RUN && pin_reset_n_f && pll_wr) |=>
      (pll_mult == $past(pll_mult_in) && pll_div == $past(pll_div_in)))
    else $error("pll write after reset not taken");

  lock_length_a: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(core_start) |-> (wait_len_reg == LOCK_LEN && $past(wait_len_reg) == LOCK_LEN - 13'h0001))
    else $error("core released after wrong lock wait");

  lock_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_LOCK) |-> core_reset)
    else $error("core out of reset during lock wait");

  core_release_a: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(core_reset) |-> (core_start && fetch_addr == RESET_VECTOR) ##1 (!core_start && !core_reset))
    else $error("core release without start at reset vector");

  ratio_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (state_reg != ST_RESET && !(state_reg == ST_RUN && pll_wr)) |=> ($stable(pll_mult) && $stable(pll_div)))
    else $error("ratio changed without software write");

  release_cover_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(core_start));
  reprogram_cover_c: cover property (@(posedge sys_clk) disable iff (srst) (state_reg == ST_RUN && pll_wr));
  rsvd_cover_c: cover property (@(posedge sys_clk) disable iff (srst) $rose(strap_reserved));
  abort_cover_c: cover property (@(posedge sys_clk) disable iff (srst)
    (state_reg == ST_LOCK) ##1 (state_reg == ST_RESET));

endmodule

/* dv/scrs_board_model.sv */
// board side: processor reset pin and ratio strap pins
// assumes the bench commands release and strap; pins change just after an edge
`timescale 1ns/1ps
module scrs_board_model
(
  input wire logic sys_clk,
  input wire logic rel_cmd,
  input wire logic [1:0] strap_cmd,
  output logic proc_reset_n,
  output logic [1:0] clk_ratio_strap,
  output logic test_reset_n,
  output logic test_clk
);
  // low from power-up until the bench first asks for a release
  // the test port is never exercised, so its reset and clock simply stay low
  initial
  begin
    proc_reset_n = 1'b0;
    clk_ratio_strap = 2'h0;
    test_reset_n = 1'b0;
    test_clk = 1'b0;
  end
  always @(posedge sys_clk)
  begin
    proc_reset_n <= rel_cmd;
    clk_ratio_strap <= strap_cmd;
  end
endmodule

/* dv/tb.sv */
// self-checking bench for the startup sequencer
// assumes the board model drives the reset and strap pins
`timescale 1ns/1ps
module tb import scrs_pkg::*;;
  typedef struct {logic [1:0] strap; logic [5:0] mult; logic rsvd;} scrs_row_s;
  logic sys_clk, srst, rel, pll_wr, core_reset, core_start, strap_reserved, pll_locked, proc_reset_n;
  logic [1:0] strap, clk_ratio_strap, pll_div_in, pll_div;
  logic [5:0] pll_mult_in, pll_mult;
  logic [23:0] fetch_addr;
  logic test_reset_n, test_clk;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  scrs_row_s rows [4] = '{'{STRAP_8, MULT_8, 1'b0}, '{STRAP_32, MULT_32, 1'b0},
                          '{STRAP_16, MULT_16, 1'b0}, '{STRAP_RSVD, MULT_8, 1'b1}};

  scrs_startup_sequencer dut (.sys_clk(sys_clk), .srst(srst), .proc_reset_n(proc_reset_n),
    .clk_ratio_strap(clk_ratio_strap), .pll_wr(pll_wr), .pll_mult_in(pll_mult_in),
    .pll_div_in(pll_div_in), .core_reset(core_reset), .core_start(core_start),
    .fetch_addr(fetch_addr), .pll_mult(pll_mult), .pll_div(pll_div),
    .strap_reserved(strap_reserved), .pll_locked(pll_locked));
  scrs_board_model board (.sys_clk(sys_clk), .rel_cmd(rel), .strap_cmd(strap),
    .proc_reset_n(proc_reset_n), .clk_ratio_strap(clk_ratio_strap),
    .test_reset_n(test_reset_n), .test_clk(test_clk));

  // free running, never halted
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic hold_reset(input logic [1:0] s);
    rel <= 1'b0;
    strap <= s;
    tick(8);
  endtask

  // edges from release request to start pulse; pin and filter add a few
  task automatic run_up();
    n = 0;
    rel <= 1'b1;
    while (core_start !== 1'b1)
    begin
      @(negedge sys_clk);
      n++;
      if (n > 4200)
      begin
        n_fail++;
        results();
      end
    end
    chk("lock_wait", 1'b1, n >= 4097 && n <= 4110);
  endtask

  initial
  begin
    srst = 1'b1;
    rel = 1'b0;
    strap = STRAP_8;
    pll_wr = 1'b0;
    pll_mult_in = 6'h00;
    pll_div_in = 2'h0;
    tick(20);
    @(negedge sys_clk);
    chk("core_reset", 1'b1, core_reset);
    chk("pll_mult", MULT_RESET, pll_mult);
    chk("pll_div", DIV_RESET, pll_div);
    chk("pll_locked", 1'b0, pll_locked);
    chk("test_reset_n", 1'b0, test_reset_n);
    chk("test_clk", 1'b0, test_clk);
    @(posedge sys_clk);
    srst <= 1'b0;
    $display("test reset done");
    foreach (rows[i])
    begin
      hold_reset(rows[i].strap);
      run_up();
      chk("core_reset", 1'b0, core_reset);
      chk("fetch_addr", RESET_VECTOR, fetch_addr);
      chk("pll_locked", 1'b1, pll_locked);
      chk("pll_mult", rows[i].mult, pll_mult);
      chk("pll_div", DIV_STARTUP, pll_div);
      chk("strap_reserved", rows[i].rsvd, strap_reserved);
      @(negedge sys_clk);
      chk("core_start", 1'b0, core_start);
      @(posedge sys_clk);
      strap <= ~rows[i].strap;
      tick(8);
      @(negedge sys_clk);
      chk("pll_mult", rows[i].mult, pll_mult);
      $display("test strap %0d done", i);
      @(posedge sys_clk);
    end
    // back-to-back writes, the last one wins
    pll_wr <= 1'b1;
    pll_mult_in <= 6'h2A;
    pll_div_in <= 2'h2;
    @(posedge sys_clk);
    pll_mult_in <= 6'h3F;
    pll_div_in <= 2'h3;
    @(posedge sys_clk);
    pll_wr <= 1'b0;
    @(negedge sys_clk);
    chk("pll_mult", 6'h3F, pll_mult);
    chk("pll_div", 2'h3, pll_div);
    $display("test pll write done");
    @(posedge sys_clk);
    // write during the lock wait is ignored, then an abort restarts the wait
    hold_reset(STRAP_16);
    rel <= 1'b1;
    tick(2000);
    pll_wr <= 1'b1;
    pll_mult_in <= 6'h05;
    @(posedge sys_clk);
    pll_wr <= 1'b0;
    rel <= 1'b0;
    @(negedge sys_clk);
    chk("pll_mult", MULT_16, pll_mult);
    tick(8);
    @(negedge sys_clk);
    chk("core_reset", 1'b1, core_reset);
    @(posedge sys_clk);
    run_up();
    chk("pll_mult", MULT_16, pll_mult);
    chk("strap_reserved", 1'b0, strap_reserved);
    $display("test abort done");
    results();
  end
endmodule
